// File: verilog/pio_consts.svh
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// register word indices; byte address is four times the index
`define PIO_PORT0_LVL 14'h03e0
`define PIO_PORT1_LVL 14'h03e1
`define PIO_PORT0_DIR 14'h03e2
`define PIO_PORT1_DIR 14'h03e3
`define PIO_PORT2_LVL 14'h03e4
`define PIO_PORT3_LVL 14'h03e5
`define PIO_PORT2_DIR 14'h03e6
`define PIO_PORT3_DIR 14'h03e7
`define PIO_PORT4_LVL 14'h03e8
`define PIO_PORT5_LVL 14'h03e9
`define PIO_PORT4_DIR 14'h03ea
`define PIO_PORT5_DIR 14'h03eb
`define PIO_PORT6_LVL 14'h03ec
`define PIO_PORT7_LVL 14'h03ed
`define PIO_PORT6_DIR 14'h03ee
`define PIO_PORT7_DIR 14'h03ef
`define PIO_PORT8_LVL 14'h03f0
`define PIO_PORT9_LVL 14'h03f1
`define PIO_PORT8_DIR 14'h03f2
`define PIO_PORT9_DIR 14'h03f3
`define PIO_PORT10_LVL 14'h03f4
`define PIO_PORT11_LVL 14'h03f5
`define PIO_PORT10_DIR 14'h03f6
`define PIO_PORT11_DIR 14'h3f73
`define PIO_PORT12_LVL 14'h03f8
`define PIO_PORT13_LVL 14'h03f9
`define PIO_PORT12_DIR 14'h03fa
`define PIO_PORT13_DIR 14'h03fb
`define PIO_PULLUP0 14'h03fc
`define PIO_PULLUP1 14'h03fd
`define PIO_PULLUP2 14'h03fe
`define PIO_PULLUP3 14'h03ff
`define PIO_RDCTL 14'h03d1
`define PIO_PROTECT 14'h03d0

// field positions
`define PIO_LATCH_SEL_BIT 0
`define PIO_DIR9_UNLOCK_BIT 2
`define PIO_UPPER_EN_BIT 31
`define PIO_PORT8_INPUT_LINE 69
`define PIO_OD_LINE0 56
`define PIO_OD_LINE1 57
`define PIO_PORT9_BASE 72
`define PIO_UPPER_BASE 88
`define PIO_UPPER_LINES 24

// reset values
`define PIO_DIR_RST 112'h0
`define PIO_LATCH_RST 112'h0
`define PIO_PULLUP_RST 32'h0
`define PIO_CTRL_RST 8'h00

// lines whose pull-ups are cut in external-bus modes: ports 0-3, port 4 lines 0-3, port 5
`define PIO_BUS_PU_MASK 112'h0000_0000_0000_0000_0000_ff0f_ffff_ffff

`endif

// File: verilog/pio_pkg.sv
package pio_pkg;
    typedef logic [111:0] pio_lines_t;
    typedef enum logic [2:0] {
        PIO_K_NONE,
        PIO_K_LVL,
        PIO_K_DIR,
        PIO_K_PUR,
        PIO_K_RDCTL,
        PIO_K_PROT
    } pio_kind_e;
    typedef struct packed {
        pio_kind_e kind;
        logic [3:0] port;
    } pio_dec_s;
endpackage

// File: verilog/pio_port_block.sv
// Design decision made here: the APB slave port.
`include "pio_consts.svh"

// How it works
// - direction bit 1 drives latch, 0 inputs
// - input line reads pin, writes still latch
// - output line reads latch, drives written value
// - pull-up needs group bit and input direction
// - external-bus modes cut listed pull-ups
// - bus-control lines ignore writes in bus modes
// - port 8 line 5 input-only, reads interrupt pin
// - peripheral output overrides direction bit
// - latch readback bit makes port 1 read latch
// - port 9 direction writable only after unlock
// - upper enable off clears ports 11-13 latches
// - port 7 lines 0,1 are open-drain
module pio_port_block (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pio_pkg::pio_lines_t pin_in,
    output pio_pkg::pio_lines_t pin_out,
    output pio_pkg::pio_lines_t pin_oe,
    output pio_pkg::pio_lines_t pullup_en,
    input wire pio_pkg::pio_lines_t periph_oe,
    input wire pio_pkg::pio_lines_t periph_out,
    input wire logic bus_mode,
    input wire pio_pkg::pio_lines_t bus_pin_mask
);
    import pio_pkg::*;

    localparam int NPORTS = 14;
    localparam int NLINES = 112;
    localparam logic [13:0] LVL_IDX [NPORTS] = '{`PIO_PORT0_LVL, `PIO_PORT1_LVL, `PIO_PORT2_LVL, `PIO_PORT3_LVL,
        `PIO_PORT4_LVL, `PIO_PORT5_LVL, `PIO_PORT6_LVL, `PIO_PORT7_LVL, `PIO_PORT8_LVL, `PIO_PORT9_LVL,
        `PIO_PORT10_LVL, `PIO_PORT11_LVL, `PIO_PORT12_LVL, `PIO_PORT13_LVL};
    localparam logic [13:0] DIR_IDX [NPORTS] = '{`PIO_PORT0_DIR, `PIO_PORT1_DIR, `PIO_PORT2_DIR, `PIO_PORT3_DIR,
        `PIO_PORT4_DIR, `PIO_PORT5_DIR, `PIO_PORT6_DIR, `PIO_PORT7_DIR, `PIO_PORT8_DIR, `PIO_PORT9_DIR,
        `PIO_PORT10_DIR, `PIO_PORT11_DIR, `PIO_PORT12_DIR, `PIO_PORT13_DIR};
    localparam logic [13:0] PUR_IDX [4] = '{`PIO_PULLUP0, `PIO_PULLUP1, `PIO_PULLUP2, `PIO_PULLUP3};
    // a literal cannot be bit-selected, so the mask lives in a named constant
    localparam pio_lines_t BUS_PU_MASK = `PIO_BUS_PU_MASK;

    // word address to register kind and port (or pull-up register) number
    function automatic pio_dec_s decode(input logic [15:0] a);
        pio_dec_s d;
        d.kind = PIO_K_NONE;
        d.port = 4'h0;
        if (a[1:0] == 2'b00) begin
            for (int i = 0; i < NPORTS; i++) begin
                if (a[15:2] == LVL_IDX[i]) begin
                    d.kind = PIO_K_LVL;
                    d.port = 4'(i);
                end
                if (a[15:2] == DIR_IDX[i]) begin
                    d.kind = PIO_K_DIR;
                    d.port = 4'(i);
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (a[15:2] == PUR_IDX[i]) begin
                    d.kind = PIO_K_PUR;
                    d.port = 4'(i);
                end
            end
            if (a[15:2] == `PIO_RDCTL) begin
                d.kind = PIO_K_RDCTL;
            end
            if (a[15:2] == `PIO_PROTECT) begin
                d.kind = PIO_K_PROT;
            end
        end
        return d;
    endfunction

    pio_lines_t latch_r, latch_nxt;
    pio_lines_t dir_r, dir_nxt;
    logic [31:0] pur_r, pur_nxt;
    logic [7:0] rdctl_r, rdctl_nxt;
    logic [7:0] prot_r, prot_nxt;
    pio_lines_t out_nxt, oe_nxt, pu_nxt, lvl_view, dir_view;
    logic [31:0] rd_word;

    // bus decode; address is stable through setup and access
    pio_dec_s dec;
    wire [6:0] base = {dec.port, 3'b000};
    wire setup_ph = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready & (dec.kind != PIO_K_NONE);
    wire upper_en = pur_r[`PIO_UPPER_EN_BIT];
    assign dec = decode(paddr);

    // per-line pin drive, pull-up and readback views
    for (genvar l = 0; l < NLINES; l++) begin : g_line
        wire is_od = (l == `PIO_OD_LINE0) || (l == `PIO_OD_LINE1);
        wire is_nmi = (l == `PIO_PORT8_INPUT_LINE);
        wire alive = !(l >= `PIO_UPPER_BASE) || upper_en;
        wire gpio_drv = dir_r[l] & alive;
        // peripheral output wins over direction bit
        wire drv = (periph_oe[l] | gpio_drv) & ~is_nmi;
        wire val = periph_oe[l] ? periph_out[l] : latch_r[l];
        // open-drain lines only ever pull low
        assign out_nxt[l] = is_od ? 1'b0 : val;
        assign oe_nxt[l] = is_od ? (drv & ~val) : drv;
        // group bit plus input direction; masked lines cut in bus modes
        assign pu_nxt[l] = pur_r[l / 4] & ~dir_r[l] & ~is_od & ~is_nmi & ~(bus_mode & BUS_PU_MASK[l]);
        // pin when input, latch when output; port 1 latch select
        // shared interrupt pin level read straight through
        assign lvl_view[l] = is_nmi ? pin_in[l] : !alive ? 1'b0 :
            ((dir_r[l] | ((l / 8 == 1) & rdctl_r[`PIO_LATCH_SEL_BIT])) ? latch_r[l] : pin_in[l]);
        assign dir_view[l] = is_nmi ? 1'b0 : dir_r[l];
    end

    // register write path
    always_comb begin
        latch_nxt = latch_r;
        dir_nxt = dir_r;
        pur_nxt = pur_r;
        rdctl_nxt = rdctl_r;
        prot_nxt = prot_r;
        if (wr_en) begin
            // unlock lasts for exactly one further write
            if (dec.kind != PIO_K_PROT) begin
                prot_nxt[`PIO_DIR9_UNLOCK_BIT] = 1'b0;
            end
            unique case (dec.kind)
                PIO_K_LVL: begin
                    for (int b = 0; b < 8; b++) begin
                        // bus-control lines locked in bus modes
                        if (!(bus_mode && bus_pin_mask[base + 7'(b)])) begin
                            latch_nxt[base + 7'(b)] = pwdata[b];
                        end
                    end
                end
                PIO_K_DIR: begin
                    if (dec.port != 4'h9 || prot_r[`PIO_DIR9_UNLOCK_BIT]) begin
                        for (int b = 0; b < 8; b++) begin
                            // bus-control lines locked in bus modes
                            if (!(bus_mode && bus_pin_mask[base + 7'(b)])) begin
                                dir_nxt[base + 7'(b)] = pwdata[b];
                            end
                        end
                    end
                end
                PIO_K_PUR: pur_nxt[{dec.port[1:0], 3'b000} +: 8] = pwdata[7:0];
                PIO_K_RDCTL: rdctl_nxt = pwdata[7:0];
                PIO_K_PROT: prot_nxt = pwdata[7:0];
                PIO_K_NONE: ;
            endcase
        end
        // no storage behind port 8 line 5 direction
        dir_nxt[`PIO_PORT8_INPUT_LINE] = 1'b0;
        // upper data registers held cleared while disabled
        if (!pur_nxt[`PIO_UPPER_EN_BIT]) begin
            latch_nxt[`PIO_UPPER_BASE +: `PIO_UPPER_LINES] = '0;
        end
    end

    // read mux, captured in setup so access sees a flop
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (dec.kind)
            PIO_K_LVL: rd_word[7:0] = lvl_view[base +: 8];
            PIO_K_DIR: rd_word[7:0] = dir_view[base +: 8];
            PIO_K_PUR: rd_word[7:0] = pur_r[{dec.port[1:0], 3'b000} +: 8];
            PIO_K_RDCTL: rd_word[7:0] = rdctl_r;
            PIO_K_PROT: rd_word[7:0] = prot_r;
            PIO_K_NONE: rd_word = 32'h0000_0000;
        endcase
    end

    // control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_r <= `PIO_LATCH_RST;
            dir_r <= `PIO_DIR_RST;
            pur_r <= `PIO_PULLUP_RST;
            rdctl_r <= `PIO_CTRL_RST;
            prot_r <= `PIO_CTRL_RST;
        end else begin
            latch_r <= latch_nxt;
            dir_r <= dir_nxt;
            pur_r <= pur_nxt;
            rdctl_r <= rdctl_nxt;
            prot_r <= prot_nxt;
        end
    end

    // pins registered; one cycle behind the control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
            pullup_en <= '0;
        end else begin
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
            pullup_en <= pu_nxt;
        end
    end

    // bus answer; read data sampled at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_ph) begin
                prdata <= rd_word;
                pslverr <= (dec.kind == PIO_K_NONE);
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

    // checks
    dir_drives_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dir_r[0] && !periph_oe[0]) |=> (pin_oe[0] && pin_out[0] == $past(latch_r[0])))
        else $error("output line not driving its latch");

    in_reads_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && dec.kind == PIO_K_LVL && dec.port == 4'h0 && !dir_r[0]) |=> prdata[0] == $past(pin_in[0]))
        else $error("input line read did not return pin level");

    out_reads_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && dec.kind == PIO_K_LVL && dec.port == 4'h2 && dir_r[16]) |=> prdata[0] == $past(latch_r[16]))
        else $error("output line read did not return latch");

    pullup_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pur_r[12] && !dir_r[48]) |=> pullup_en[48])
        else $error("pull-up missing on input line");

    bus_pu_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_mode |=> pullup_en[35:0] == 36'h0 && pullup_en[47:40] == 8'h00)
        else $error("pull-up connected in bus mode");

    bus_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && dec.kind == PIO_K_DIR && dec.port == 4'h0 && bus_mode && bus_pin_mask[0]) |=> $stable(dir_r[0]))
        else $error("locked bus pin direction changed");

    nmi_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 !pin_oe[`PIO_PORT8_INPUT_LINE] && !pullup_en[`PIO_PORT8_INPUT_LINE])
        else $error("input-only line driven or pulled");

    periph_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (periph_oe[3] && !dir_r[3]) |=> pin_oe[3] && pin_out[3] == $past(periph_out[3]))
        else $error("peripheral output not driven");

    dir9_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && dec.kind == PIO_K_DIR && dec.port == 4'h9 && !prot_r[`PIO_DIR9_UNLOCK_BIT])
        |=> $stable(dir_r[`PIO_PORT9_BASE +: 8]))
        else $error("port 9 direction written while locked");

    upper_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !upper_en |-> latch_r[`PIO_UPPER_BASE +: `PIO_UPPER_LINES] == 24'h0)
        else $error("upper port latch not cleared");

    open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 !(pin_oe[`PIO_OD_LINE0] && pin_out[`PIO_OD_LINE0]) && !(pin_oe[`PIO_OD_LINE1] && pin_out[`PIO_OD_LINE1]))
        else $error("open-drain line driven high");
endmodule

// File: test/pio_pins_model.sv
// far-side circuitry: resolves each pin from device drive, external drive and pull-up
module pio_pins_model (
    input wire logic pclk,
    input wire pio_pkg::pio_lines_t pin_out,
    input wire pio_pkg::pio_lines_t pin_oe,
    input wire pio_pkg::pio_lines_t pullup_en,
    input wire pio_pkg::pio_lines_t ext_lvl,
    input wire pio_pkg::pio_lines_t ext_en,
    output pio_pkg::pio_lines_t pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
    pio_lines_t float_r = 112'h0;

    // a floating line toggles each cycle so a stale level never looks valid
    always @(posedge pclk) begin
        float_r <= ~float_r;
    end

    // open-drain and input-only lines follow the far side unless pulled low
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl) |
        (~pin_oe & ~ext_en & pullup_en) | (~pin_oe & ~ext_en & ~pullup_en & float_r);
endmodule

// File: test/programmable_io_ports_bench.sv
`include "pio_consts.svh"

module programmable_io_ports_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_mode, ev;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rv;
    pio_lines_t pin_in, pin_out, pin_oe, pullup_en, periph_oe, periph_out, bus_pin_mask, ext_lvl, ext_en;
    logic [13:0] dirs [0:5] = '{`PIO_PORT0_DIR, `PIO_PORT1_DIR, `PIO_PORT9_DIR, `PIO_PORT11_DIR, `PIO_PORT13_DIR,
        `PIO_PULLUP0};
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    pio_port_block pio_port_block_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .periph_oe(periph_oe),
        .periph_out(periph_out), .bus_mode(bus_mode), .bus_pin_mask(bus_pin_mask));
    pio_pins_model pio_pins_model_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_in(pin_in));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // hang guard, far above the roughly 200 cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("Error at %0t: run did not finish", $time);
            stop_test();
        end
    end

    task stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; an idle cycle follows so no signal is driven twice in a step
    task apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        rv = prdata[7:0];
        ev = pslverr;
        chk(n, 0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [13:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task rd(input logic [13:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rv, e);
    endtask

    // pin outputs lag the register by one edge; three edges leave margin
    task settle;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        periph_oe = '0;
        periph_out = '0;
        bus_mode = 1'b0;
        bus_pin_mask = '0;
        ext_lvl = '0;
        ext_en = '1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) rd(dirs[i], 8'h00);
        chk(pin_oe[31:0], 32'h0);
        // output lines drive the latch
        wr(`PIO_PORT0_DIR, 8'hff);
        wr(`PIO_PORT0_LVL, 8'ha5);
        settle();
        rd(`PIO_PORT0_LVL, 8'ha5);
        chk(pin_oe[7:0], 8'hff);
        chk(pin_out[7:0], 8'ha5);
        // input lines read the pin, pull-up follows group bit and direction
        ext_lvl[23:16] <= 8'h3c;
        wr(`PIO_PORT2_LVL, 8'h99);
        wr(`PIO_PULLUP0, 8'h10);
        settle();
        rd(`PIO_PORT2_LVL, 8'h3c);
        chk(pin_oe[23:16], 8'h00);
        chk(pullup_en[23:16], 8'h0f);
        wr(`PIO_PORT2_DIR, 8'h01);
        settle();
        chk(pullup_en[19:16], 4'he);
        rd(`PIO_PORT2_LVL, 8'h3d);
        chk(pin_out[16], 1'b1);
        // external-bus mode locks bus pins and cuts pull-ups
        bus_mode <= 1'b1;
        bus_pin_mask[7:0] <= 8'hff;
        settle();
        chk(pullup_en[19:16], 4'h0);
        wr(`PIO_PULLUP0, 8'h11);
        rd(`PIO_PULLUP0, 8'h11);
        wr(`PIO_PORT0_LVL, 8'h11);
        wr(`PIO_PORT0_DIR, 8'h00);
        rd(`PIO_PORT0_LVL, 8'ha5);
        rd(`PIO_PORT0_DIR, 8'hff);
        bus_mode <= 1'b0;
        settle();
        chk(pullup_en[19:16], 4'he);
        // outside bus modes port 0 becomes an input and reads its pins
        wr(`PIO_PORT0_DIR, 8'h00);
        rd(`PIO_PORT0_LVL, 8'h00);
        // shared interrupt line is input only; software keeps bit 5 at zero
        ext_lvl[69] <= 1'b1;
        wr(`PIO_PORT8_DIR, 8'hdf);
        settle();
        rd(`PIO_PORT8_DIR, 8'hdf);
        rd(`PIO_PORT8_LVL, 8'h20);
        chk(pin_oe[69], 1'b0);
        ext_lvl[69] <= 1'b0;
        settle();
        rd(`PIO_PORT8_LVL, 8'h00);
        // peripheral output overrides an input direction
        wr(`PIO_PORT6_DIR, 8'h00);
        wr(`PIO_PULLUP1, 8'h10);
        periph_oe[48] <= 1'b1;
        periph_out[48] <= 1'b1;
        settle();
        chk(pullup_en[48], 1'b1);
        chk(pin_oe[48], 1'b1);
        chk(pin_out[48], 1'b1);
        periph_oe[48] <= 1'b0;
        settle();
        chk(pin_oe[48], 1'b0);
        // latch readback for port 1
        wr(`PIO_PORT1_LVL, 8'h5a);
        rd(`PIO_PORT1_LVL, 8'h00);
        wr(`PIO_RDCTL, 8'h01);
        rd(`PIO_PORT1_LVL, 8'h5a);
        // port 9 direction needs a fresh unlock each time
        wr(`PIO_PORT9_DIR, 8'hff);
        rd(`PIO_PORT9_DIR, 8'h00);
        wr(`PIO_PROTECT, 8'h04);
        wr(`PIO_PORT9_DIR, 8'h0f);
        rd(`PIO_PORT9_DIR, 8'h0f);
        wr(`PIO_PORT9_DIR, 8'hff);
        rd(`PIO_PORT9_DIR, 8'h0f);
        settle();
        chk(pin_oe[79:72], 8'h0f);
        // upper ports run only while enabled
        wr(`PIO_PORT12_LVL, 8'hff);
        rd(`PIO_PORT12_LVL, 8'h00);
        wr(`PIO_PULLUP3, 8'h80);
        wr(`PIO_PORT12_DIR, 8'hff);
        wr(`PIO_PORT12_LVL, 8'hc3);
        settle();
        rd(`PIO_PORT12_LVL, 8'hc3);
        chk(pin_out[103:96], 8'hc3);
        wr(`PIO_PULLUP3, 8'h00);
        settle();
        rd(`PIO_PORT12_LVL, 8'h00);
        chk(pin_oe[103:96], 8'h00);
        // open-drain lines only pull low
        wr(`PIO_PORT7_DIR, 8'h03);
        wr(`PIO_PORT7_LVL, 8'h01);
        settle();
        chk(pin_oe[57:56], 2'b10);
        chk(pin_out[57], 1'b0);
        // unmapped word is refused
        apb(1'b0, 14'h03f7, 8'h00);
        chk(ev, 1'b1);
        chk(rv, 8'h00);
        stop_test();
    end
endmodule
